// ===== rtl/ddrcf_pkg.sv
// ddrcf_pkg: constants, enums and carriers for the command/control front end
// assumes a single 25 MHz clock domain; all pins arrive already synchronous
package ddrcf_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int REFI_EXT_NS   = 3900;
  localparam int RETAIN_EXT_MS = 32;
  // shortened refresh interval rounds down to whole cycles
  localparam int REFI_EXT_CYC  = REFI_EXT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // sizes and field positions
  // ----------------------------------------------------------------------
  localparam int NUM_BANKS     = 8;
  localparam int BANK_W        = 3;
  localparam int ADDR_W        = 15;
  localparam int MR_ODT_DIS    = 0;
  localparam int MR_AUTOSR_BIT = 6;
  localparam int MR_EXTSR_BIT  = 7;
  localparam int MR1_IDX       = 1;
  localparam int MR_SECOND_IDX = 2;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 8'h00;

  typedef enum logic [3:0] {
    DDRCF_CMD_DESEL,
    DDRCF_CMD_NOP,
    DDRCF_CMD_ACT,
    DDRCF_CMD_RD,
    DDRCF_CMD_WR,
    DDRCF_CMD_PRE,
    DDRCF_CMD_REF,
    DDRCF_CMD_MRS,
    DDRCF_CMD_ZQC
  } ddrcf_cmd_e;

  typedef enum logic [1:0] {
    DDRCF_PWR_ON,
    DDRCF_PWR_PPD,
    DDRCF_PWR_APD,
    DDRCF_PWR_SR
  } ddrcf_pwr_e;

  // command pins as presented by the controller
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrcf_pins_s;

  // decoded command handed to the core
  typedef struct packed {
    logic              valid;
    ddrcf_cmd_e        cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrcf_dcmd_s;

endpackage

// ===== rtl/ddrcf_decode.sv
// ddrcf_decode: registered command decoder for the four command pins
// assumes pins are already gated by the clock-enable / buffer logic
`timescale 1ns/1ps
module ddrcf_decode import ddrcf_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // sampled pins
  input  wire logic        sample_en,
  input  wire ddrcf_pins_s pins,
  // decoded command
  output ddrcf_dcmd_s      dcmd
);

  ddrcf_dcmd_s state_q;
  ddrcf_dcmd_s state_d;

  always_comb begin
    state_d       = state_q;
    state_d.valid = 1'b0;
    state_d.cmd   = DDRCF_CMD_DESEL;
    if (sample_en) begin
      state_d.bank = pins.bank;
      state_d.addr = pins.addr;
      if (!pins.cs_n) begin
        state_d.valid = 1'b1;
        case ({pins.ras_n, pins.cas_n, pins.we_n})
          3'h7:    state_d.cmd = DDRCF_CMD_NOP;
          3'h3:    state_d.cmd = DDRCF_CMD_ACT;
          3'h5:    state_d.cmd = DDRCF_CMD_RD;
          3'h4:    state_d.cmd = DDRCF_CMD_WR;
          3'h2:    state_d.cmd = DDRCF_CMD_PRE;
          3'h1:    state_d.cmd = DDRCF_CMD_REF;
          3'h0:    state_d.cmd = DDRCF_CMD_MRS;
          3'h6:    state_d.cmd = DDRCF_CMD_ZQC;
          default: state_d.cmd = DDRCF_CMD_NOP;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dcmd = state_q;

  a_desel_masks: assert property (@(posedge clk) disable iff (rst)
    (sample_en && pins.cs_n) |=> !dcmd.valid)
    else $error("command taken while chip select high");

  a_act_code: assert property (@(posedge clk) disable iff (rst)
    (sample_en && !pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h3)
      |=> (dcmd.valid && dcmd.cmd == DDRCF_CMD_ACT))
    else $error("activate code not decoded");

  a_rd_code: assert property (@(posedge clk) disable iff (rst)
    (sample_en && !pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h5)
      |=> (dcmd.cmd == DDRCF_CMD_RD && dcmd.bank == $past(pins.bank)))
    else $error("read code or bank not decoded");

endmodule

// ===== rtl/ddrcf_front.sv
// ddrcf_front: command/control input front end of a 16-bit 8-bank DDR3-style device
// assumes clk is the differential-crossing clock and all pins are synchronous to it
//
// Summary of operation
// - sample address and control on clock crossing
// - clock enable high runs clocks and buffers
// - clock enable low: idle->precharge/self-refresh, open->active
// - self-refresh exit on clock enable alone
// - power-down keeps only clock, termination, enable buffers
// - self-refresh keeps only clock enable buffer
// - chip select high masks the command
// - termination enable drives all data-side terminations
// - termination ignored if disabled or self-refresh
// - command coded by four command pins
// - reset low clears state, contents lost
// - bank pins choose bank or mode register
`timescale 1ns/1ps
module ddrcf_front import ddrcf_pkg::*; #(
  parameter int REFI_CYC = REFI_EXT_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 reset_n,
  // command and control pins
  input  wire logic                 cke,
  input  wire ddrcf_pins_s          pins,
  input  wire logic                 odt,
  // configuration and environment
  input  wire logic                 hot_case,
  // power and buffer status
  output ddrcf_pwr_e                pwr_state,
  output logic                      int_clk_en,
  output logic                      cmd_buf_en,
  output logic                      ck_buf_en,
  output logic                      odt_buf_en,
  output logic                      out_drv_en,
  // termination
  output logic [15:0]               dq_term_en,
  output logic [1:0]                dqs_term_en,
  output logic [1:0]                dm_term_en,
  // decoded command and bank state
  output ddrcf_dcmd_s               cmd_out,
  output logic [NUM_BANKS-1:0]      bank_open,
  output logic                      mr_odt_off,
  output logic                      automatic_self_refresh_mode,
  output logic                      ext_temp_ok,
  output logic                      refresh_late
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    ddrcf_pwr_e           pwr;
    logic                 cke_prev;
    logic [NUM_BANKS-1:0] open;
    logic                 mr1_odt_off;
    logic                 mr_second_odt_off;
    logic                 auto_sr;
    logic                 srt;
    logic [15:0]          dq_t;
    logic [1:0]           dqs_t;
    logic [1:0]           dm_t;
    logic [31:0]          refi_cnt;
    logic                 late;
    logic                 clk_on;
    logic                 cmd_buf;
    logic                 ck_buf;
    logic                 odt_buf;
    logic                 odt_off;
    logic                 ext_ok;
  } ddrcf_state_s;

  ddrcf_state_s st_q;
  ddrcf_state_s st_d;
  ddrcf_dcmd_s  dcmd;
  logic         active;
  logic         odt_live;

  // commands only sampled while clocks run and the front buffers are on
  assign active = (st_q.pwr == DDRCF_PWR_ON) && cke;

  ddrcf_decode ddrcf_decode_inst (
    .clk       (clk),
    .rst       (rst || !reset_n),
    .sample_en (active),
    .pins      (pins),
    .dcmd      (dcmd)
  );

  // termination input is listened to in power-down, never in self-refresh
  assign odt_live = odt && (st_q.pwr != DDRCF_PWR_SR)
                 && !(st_q.mr1_odt_off && st_q.mr_second_odt_off);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.cke_prev = cke;
    case (st_q.pwr)
      DDRCF_PWR_ON: begin
        if (!cke) begin
          // refresh with clock enable low and all banks idle is the self-refresh entry
          if (st_q.open != BANKS_IDLE) begin
            st_d.pwr = DDRCF_PWR_APD;
          end else if (!pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} == 3'h1) begin
            st_d.pwr = DDRCF_PWR_SR;
          end else begin
            st_d.pwr = DDRCF_PWR_PPD;
          end
        end
      end
      DDRCF_PWR_PPD, DDRCF_PWR_APD: begin
        if (cke) begin
          st_d.pwr = DDRCF_PWR_ON;
        end
      end
      DDRCF_PWR_SR: begin
        // exit keyed on the enable level only, no command edge needed
        if (cke) begin
          st_d.pwr = DDRCF_PWR_ON;
        end
      end
      default: st_d.pwr = DDRCF_PWR_ON;
    endcase

    if (dcmd.valid) begin
      case (dcmd.cmd)
        DDRCF_CMD_ACT: st_d.open[dcmd.bank] = 1'b1;
        DDRCF_CMD_PRE: begin
          if (dcmd.addr[10]) begin
            st_d.open = BANKS_IDLE;
          end else begin
            st_d.open[dcmd.bank] = 1'b0;
          end
        end
        DDRCF_CMD_RD, DDRCF_CMD_WR: begin
          if (dcmd.addr[10]) begin
            st_d.open[dcmd.bank] = 1'b0;
          end
        end
        DDRCF_CMD_MRS: begin
          // bank pins pick the mode register being written
          if (dcmd.bank == BANK_W'(MR1_IDX)) begin
            st_d.mr1_odt_off = dcmd.addr[MR_ODT_DIS];
          end else if (dcmd.bank == BANK_W'(MR_SECOND_IDX)) begin
            st_d.mr_second_odt_off = dcmd.addr[MR_ODT_DIS];
            st_d.auto_sr           = dcmd.addr[MR_AUTOSR_BIT];
            st_d.srt               = dcmd.addr[MR_EXTSR_BIT];
          end
        end
        default: ;
      endcase
    end

    // refresh watchdog: flags a missed double-rate interval when hot
    if (dcmd.valid && dcmd.cmd == DDRCF_CMD_REF) begin
      st_d.refi_cnt = '0;
      st_d.late     = 1'b0;
    end else if (st_q.pwr == DDRCF_PWR_SR || !hot_case) begin
      st_d.refi_cnt = '0;
    end else if (st_q.refi_cnt >= 32'(REFI_CYC)) begin
      st_d.late = 1'b1;
    end else begin
      st_d.refi_cnt = st_q.refi_cnt + 32'h1;
    end

    st_d.dq_t  = {16{odt_live}};
    st_d.dqs_t = {2{odt_live}};
    st_d.dm_t  = {2{odt_live}};

    // status flops built from the next state, so they line up with it
    st_d.clk_on  = (st_d.pwr == DDRCF_PWR_ON) && cke;
    st_d.cmd_buf = (st_d.pwr == DDRCF_PWR_ON);
    st_d.ck_buf  = (st_d.pwr != DDRCF_PWR_SR);
    st_d.odt_buf = (st_d.pwr != DDRCF_PWR_SR);
    st_d.odt_off = st_d.mr1_odt_off && st_d.mr_second_odt_off;
    st_d.ext_ok  = st_d.auto_sr || st_d.srt;
  end

  always_ff @(posedge clk) begin
    // pin reset treated as a clear with the device clock; contents are dropped
    if (rst || !reset_n) begin
      st_q         <= '0;
      st_q.cmd_buf <= 1'b1;
      st_q.ck_buf  <= 1'b1;
      st_q.odt_buf <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign pwr_state   = st_q.pwr;
  assign int_clk_en  = st_q.clk_on;
  assign out_drv_en  = st_q.clk_on;
  assign cmd_buf_en  = st_q.cmd_buf;
  assign ck_buf_en   = st_q.ck_buf;
  assign odt_buf_en  = st_q.odt_buf;
  assign dq_term_en  = st_q.dq_t;
  assign dqs_term_en = st_q.dqs_t;
  assign dm_term_en  = st_q.dm_t;
  assign cmd_out     = dcmd;
  assign bank_open   = st_q.open;
  assign mr_odt_off  = st_q.odt_off;
  assign automatic_self_refresh_mode = st_q.auto_sr;
  assign ext_temp_ok = st_q.ext_ok;
  assign refresh_late = st_q.late;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_idle_drop;
    (st_q.pwr == DDRCF_PWR_ON) && !cke && (st_q.open == BANKS_IDLE);
  endsequence

  a_pd_idle: assert property (@(posedge clk) disable iff (rst || !reset_n)
    s_idle_drop |=> (pwr_state == DDRCF_PWR_PPD || pwr_state == DDRCF_PWR_SR))
    else $error("idle drop of enable not a precharge power-down");

  a_pd_active: assert property (@(posedge clk) disable iff (rst || !reset_n)
    ((st_q.pwr == DDRCF_PWR_ON) && !cke && (st_q.open != BANKS_IDLE)) |=> pwr_state == DDRCF_PWR_APD)
    else $error("open-row drop of enable not an active power-down");

  a_sr_exit: assert property (@(posedge clk) disable iff (rst || !reset_n)
    (pwr_state == DDRCF_PWR_SR && cke) |=> pwr_state == DDRCF_PWR_ON)
    else $error("self-refresh not left on enable high");

  a_sr_buffers: assert property (@(posedge clk) disable iff (rst || !reset_n)
    pwr_state == DDRCF_PWR_SR |-> (!ck_buf_en && !odt_buf_en && !cmd_buf_en))
    else $error("buffers live in self-refresh");

  a_pd_buffers: assert property (@(posedge clk) disable iff (rst || !reset_n)
    (pwr_state == DDRCF_PWR_PPD || pwr_state == DDRCF_PWR_APD) |-> (ck_buf_en && !cmd_buf_en))
    else $error("power-down buffer set wrong");

  a_odt_follow: assert property (@(posedge clk) disable iff (rst || !reset_n)
    (odt && pwr_state == DDRCF_PWR_ON && !mr_odt_off) |=> (&dq_term_en && &dqs_term_en && &dm_term_en))
    else $error("termination not applied");

  a_odt_sr_off: assert property (@(posedge clk) disable iff (rst || !reset_n)
    (pwr_state == DDRCF_PWR_SR) |=> (dq_term_en == 16'h0000))
    else $error("termination applied in self-refresh");

  a_clk_stop: assert property (@(posedge clk) disable iff (rst || !reset_n)
    !cke |=> !int_clk_en)
    else $error("internal clocks run with enable low");

  a_reset_clr: assert property (@(posedge clk)
    !reset_n |=> (bank_open == BANKS_IDLE && pwr_state == DDRCF_PWR_ON))
    else $error("pin reset did not clear state");

endmodule

// ===== tb/ddrcf_ctrl_model.sv
// ddrcf_ctrl_model: behavioural memory controller that drives the command pins
// assumes the caller moves it a fixed small delay after the clock's rising edge
`timescale 1ns/1ps
module ddrcf_ctrl_model import ddrcf_pkg::*; (
  // driven pins
  output ddrcf_pins_s pins,
  output logic        cke,
  output logic        odt
);
  initial begin
    pins = {4'hF, 3'h0, 15'h0000};
    cke  = 1'b1;
    odt  = 1'b0;
  end

  // one command, held until the caller's next move
  task automatic issue(input logic [3:0] code, input logic [2:0] ba, input logic [14:0] a);
    pins = {code, ba, a};
    if (code[2:0] == 3'h5 || code[2:0] == 3'h4) begin
      cke = 1'b1;
    end
  endtask

  // deselected: bank and address lines never keep their last value
  task automatic idle();
    pins = {4'hF, ~pins.bank, ~pins.addr};
  endtask

  task automatic set_lv(input logic c, input logic o);
    cke = c;
    odt = o;
  endtask
endmodule

// ===== tb/ddrcf_front_tb.sv
// ddrcf_front_tb: directed tests of the command/control front end
// assumes a 25 MHz clock and a short refresh interval parameter
`timescale 1ns/1ps
module ddrcf_front_tb import ddrcf_pkg::*; ;
  localparam int REFI = 8;
  localparam logic [3:0] CODES [8] = '{4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0, 4'h6};
  localparam ddrcf_cmd_e KINDS [8] = '{DDRCF_CMD_NOP, DDRCF_CMD_ACT, DDRCF_CMD_RD, DDRCF_CMD_WR,
                                       DDRCF_CMD_PRE, DDRCF_CMD_REF, DDRCF_CMD_MRS, DDRCF_CMD_ZQC};
  logic                 clk, rst, reset_n, hot_case, cke, odt;
  ddrcf_pins_s          pins;
  ddrcf_pwr_e           pwr_state;
  logic                 int_clk_en, cmd_buf_en, ck_buf_en, odt_buf_en, out_drv_en;
  logic [15:0]          dq_term_en;
  logic [1:0]           dqs_term_en, dm_term_en;
  ddrcf_dcmd_s          cmd_out;
  logic [NUM_BANKS-1:0] bank_open;
  logic                 mr_odt_off, automatic_self_refresh_mode, ext_temp_ok, refresh_late;
  int                   err_count, checks;

  ddrcf_ctrl_model ddrcf_ctrl_model_inst (.pins(pins), .cke(cke), .odt(odt));
  ddrcf_front #(.REFI_CYC(REFI)) ddrcf_front_inst (
    .clk(clk), .rst(rst), .reset_n(reset_n), .cke(cke), .pins(pins), .odt(odt), .hot_case(hot_case),
    .pwr_state(pwr_state), .int_clk_en(int_clk_en), .cmd_buf_en(cmd_buf_en), .ck_buf_en(ck_buf_en),
    .odt_buf_en(odt_buf_en), .out_drv_en(out_drv_en), .dq_term_en(dq_term_en),
    .dqs_term_en(dqs_term_en), .dm_term_en(dm_term_en), .cmd_out(cmd_out), .bank_open(bank_open),
    .mr_odt_off(mr_odt_off), .automatic_self_refresh_mode(automatic_self_refresh_mode),
    .ext_temp_ok(ext_temp_ok), .refresh_late(refresh_late));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cmd(input logic v, input ddrcf_cmd_e k, input logic [2:0] b);
    chk(24'({cmd_out.valid, cmd_out.bank, cmd_out.cmd}), 24'({v, b, k}));
  endtask

  task automatic conclude();
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard, far beyond the roughly 60 cycles the tests need
  initial begin
    #(40 * 3000);
    err_count++;
    conclude();
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reset_n = 1'b1;
    hot_case = 1'b0;
    err_count = 0;
    checks = 0;
    step(16);
    rst = 1'b0;
    chk(24'({pwr_state, cmd_buf_en, ck_buf_en, odt_buf_en, bank_open, cmd_out.valid}),
        24'({DDRCF_PWR_ON, 3'h7, 9'h000}));
    // a10 high: the precharge in the sweep closes the row the activate opened
    for (int i = 0; i < 8; i++) begin
      ddrcf_ctrl_model_inst.issue(CODES[i], 3'(i), 15'h0400);
      step();
      chk_cmd(1'b1, KINDS[i], 3'(i));
    end
    ddrcf_ctrl_model_inst.issue(4'hB, 3'h3, 15'h0000);
    step();
    chk(24'(cmd_out.valid), 24'h000000);
    ddrcf_ctrl_model_inst.issue(4'h3, 3'h3, 15'h1234);
    step();
    chk(24'(bank_open), 24'h000000);
    chk_cmd(1'b1, DDRCF_CMD_ACT, 3'h3);
    ddrcf_ctrl_model_inst.idle();
    step();
    chk(24'(bank_open), 24'h000008);
    // open row: clock enable low gives active power-down
    ddrcf_ctrl_model_inst.set_lv(1'b0, 1'b0);
    step();
    chk(24'(pwr_state), 24'(DDRCF_PWR_APD));
    ddrcf_ctrl_model_inst.issue(4'h3, 3'h5, 15'h0000);
    step();
    chk(24'({int_clk_en, cmd_buf_en, ck_buf_en, odt_buf_en, out_drv_en, cmd_out.valid}), 24'h00000C);
    ddrcf_ctrl_model_inst.idle();
    ddrcf_ctrl_model_inst.set_lv(1'b1, 1'b0);
    step();
    chk(24'({pwr_state, bank_open}), 24'({DDRCF_PWR_ON, 8'h08}));
    ddrcf_ctrl_model_inst.issue(4'h2, 3'h0, 15'h0400);
    step();
    chk(24'({int_clk_en, cmd_buf_en, ck_buf_en, odt_buf_en, out_drv_en}), 24'h00001F);
    ddrcf_ctrl_model_inst.idle();
    step();
    chk(24'(bank_open), 24'h000000);
    ddrcf_ctrl_model_inst.set_lv(1'b0, 1'b0);
    step();
    chk(24'(pwr_state), 24'(DDRCF_PWR_PPD));
    ddrcf_ctrl_model_inst.set_lv(1'b1, 1'b1);
    step();
    step();
    chk(24'({dq_term_en, dqs_term_en, dm_term_en}), 24'h0FFFFF);
    // refresh code with enable low enters self-refresh; termination request ignored there
    ddrcf_ctrl_model_inst.issue(4'h1, 3'h0, 15'h0000);
    ddrcf_ctrl_model_inst.set_lv(1'b0, 1'b1);
    step();
    chk(24'(pwr_state), 24'(DDRCF_PWR_SR));
    ddrcf_ctrl_model_inst.idle();
    step(2);
    chk(24'({ck_buf_en, odt_buf_en, cmd_buf_en, dq_term_en, dqs_term_en, dm_term_en}), 24'h000000);
    ddrcf_ctrl_model_inst.set_lv(1'b1, 1'b0);
    step();
    chk(24'(pwr_state), 24'(DDRCF_PWR_ON));
    // both mode registers disable termination; automatic self-refresh chosen
    ddrcf_ctrl_model_inst.issue(4'h0, 3'h1, 15'h0001);
    step();
    ddrcf_ctrl_model_inst.issue(4'h0, 3'h2, 15'h0041);
    step();
    ddrcf_ctrl_model_inst.idle();
    ddrcf_ctrl_model_inst.set_lv(1'b1, 1'b1);
    step(2);
    chk(24'({mr_odt_off, automatic_self_refresh_mode, ext_temp_ok, dq_term_en}), 24'h070000);
    ddrcf_ctrl_model_inst.issue(4'h0, 3'h2, 15'h0080);
    step();
    ddrcf_ctrl_model_inst.idle();
    step();
    chk(24'({mr_odt_off, automatic_self_refresh_mode, ext_temp_ok}), 24'h000001);
    // hot case: refresh overdue after the shortened interval
    hot_case = 1'b1;
    ddrcf_ctrl_model_inst.issue(4'h1, 3'h0, 15'h0000);
    step();
    ddrcf_ctrl_model_inst.idle();
    step(REFI - 3);
    chk(24'(refresh_late), 24'h000000);
    step(6);
    chk(24'(refresh_late), 24'h000001);
    ddrcf_ctrl_model_inst.issue(4'h1, 3'h0, 15'h0000);
    step();
    ddrcf_ctrl_model_inst.issue(4'h3, 3'h6, 15'h0000);
    step();
    ddrcf_ctrl_model_inst.idle();
    step();
    chk(24'({refresh_late, bank_open}), 24'h000040);
    reset_n = 1'b0;
    step();
    reset_n = 1'b1;
    chk(24'({pwr_state, bank_open, mr_odt_off}), 24'h000000);
    conclude();
  end
endmodule
